// >>> core/pbw_pkg.sv
// constants, register map and state type of the push-button wake controller
// assumes a single 250 MHz clock domain and an AHB-Lite register slave
package pbw_pkg;

    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int PULSE_US = 128;
    localparam int PULSE_CYCLES = PULSE_US * CLK_MHZ;
    localparam int CYCLE_OFF_US = 2000;
    localparam int CYCLE_OFF_CYCLES = CYCLE_OFF_US * CLK_MHZ;

    // timer counts are in ticks; the long-press fields are in units of 16 ticks
    localparam int TIMER_W = 12;
    localparam int LONG_SHIFT = 4;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_POWER = 8'h14;
    localparam logic [7:0] ADDR_STATE = 8'h18;

    localparam int CTRL_FIRST_LSB = 0;
    localparam int CTRL_SECOND_LSB = 8;
    localparam int CTRL_LONG_LSB = 16;
    localparam int CTRL_WARN_LSB = 24;
    localparam int CTRL_ACTION_LSB = 28;
    localparam logic [31:0] CTRL_RESET = 32'h0264_3214;

    localparam int POWER_AUX_BIT = 0;
    localparam int POWER_STORE_BIT = 1;
    localparam logic [1:0] POWER_RESET = 2'h0;

    localparam int EV_FIRST = 0;
    localparam int EV_SECOND = 1;
    localparam int EV_WARN = 2;
    localparam int EV_LONG = 3;
    localparam int EV_WAKE = 4;
    localparam int NUM_FLAGS = 3;
    localparam int NUM_EV = 5;
    localparam logic [NUM_EV-1:0] IRQ_EN_RESET = 5'h07;

    localparam logic [1:0] ACT_PCYCLE = 2'h0;
    localparam logic [1:0] ACT_STORAGE = 2'h1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        st_storage,
        st_wake_try,
        st_active,
        st_pcycle
    } pbw_state_t;

endpackage

// >>> core/pbw_press_timer.sv
// one button press timer counting ticks while the button is held
// assumes start is a one-cycle pulse on the falling edge of the button
`timescale 1ns/1ps
module pbw_press_timer #(
    parameter int W = 12
) (
    input wire logic sys_clk, // clock
    input wire logic rstn, // async reset, active low
    input wire logic tick, // timebase tick pulse
    input wire logic start, // button falling edge
    input wire logic held, // button is held low
    input wire logic [W-1:0] duration, // programmed duration in ticks
    output logic expired // one-cycle pulse on expiry
);
    logic [W-1:0] count;
    logic [W-1:0] dur_q;
    logic run;
    wire logic [W-1:0] count_inc = count + {{(W-1){1'b0}}, 1'b1};
    wire logic reach = run && tick && (count_inc >= dur_q);

    // the duration is latched at the start so a rewrite mid-press has no effect
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
            dur_q <= '0;
            run <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                count <= '0;
                dur_q <= duration;
                run <= 1'b1;
            end else if (!held) begin
                count <= '0;
                run <= 1'b0;
            end else if (reach) begin
                run <= 1'b0;
                expired <= 1'b1;
            end else if (run && tick) begin
                count <= count_inc;
            end
        end
    end
endmodule

// >>> core/pbw_int_pulse.sv
// stretches a trigger into a fixed-length active-low open-drain interrupt pulse
// assumes the pin is pulled up outside; a retrigger restarts the pulse
`timescale 1ns/1ps
module pbw_int_pulse #(
    parameter int PULSE_CYCLES = 32000
) (
    input wire logic sys_clk, // clock
    input wire logic rstn, // async reset, active low
    input wire logic trigger, // start a pulse
    output logic int_oe_n // pin enable, low while pulling the pin low
);
    localparam int CW = $clog2(PULSE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);

    logic [CW-1:0] count;
    logic active;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
            active <= 1'b0;
        end else if (trigger) begin
            count <= '0;
            active <= 1'b1;
        end else if (active) begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
            active <= (count != LAST);
        end
    end

    assign int_oe_n = ~active;
endmodule

// >>> core/pbw_top.sv
// push-button wake controller: press timers, flags, interrupts and rail control
// assumes button and supply detector inputs are synchronous to sys_clk
// and a single AHB-Lite master with whole-word single transfers
//
// Behaviour
// - button wakes, reports presses, long-press actions
// - running timer keeps its old duration
// - first timer: 128 us pulse, flag
// - second timer: second pulse and flag
// - first timer qualifies wake; second only reports
// - press flags clear when host reads them
// - pulse only when flag newly set
// - durations programmable in button control register
// - storage: button falling edge enables digital rail
// - held past first timer: system rail up
// - early release returns to storage mode
// - after wake, suppress until button retoggled
// - valid supply during wake exits storage
// - long-press expiry runs selected action
// - warning interrupt and flag before long expiry
// - masked conditions give no pulse
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module pbw_top #(
    parameter int TICK_CYCLES = pbw_pkg::TICK_CYCLES,
    parameter int PULSE_CYCLES = pbw_pkg::PULSE_CYCLES,
    parameter int CYCLE_OFF_CYCLES = pbw_pkg::CYCLE_OFF_CYCLES
) (
    input wire logic sys_clk, // clock, 250 MHz
    input wire logic rstn, // async reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic [31:0] hrdata, // AHB read data
    output logic hresp, // AHB response, always OKAY
    input wire logic button_input_n, // push button, low when pressed
    input wire logic vin_valid, // input supply above undervoltage
    output logic int_out, // interrupt pin output value
    output logic int_oe_n, // interrupt pin enable, low while driving
    output logic irq, // level interrupt from enabled status
    output logic digital_rail_en, // digital supply rail enable
    output logic system_rail_en, // system rail enable
    output logic aux_rail_en // auxiliary regulator enable
);
    localparam int TW = pbw_pkg::TIMER_W;
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam int OW = $clog2(CYCLE_OFF_CYCLES + 1);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);
    localparam logic [OW-1:0] OFF_LAST = OW'(CYCLE_OFF_CYCLES - 1);
    localparam int NF = pbw_pkg::NUM_FLAGS;
    localparam int NE = pbw_pkg::NUM_EV;

    generate
        if (TICK_CYCLES < 1 || PULSE_CYCLES < 1 || CYCLE_OFF_CYCLES < 1) begin : g_bad
            $error("pbw_top: cycle counts must be at least one");
        end
    endgenerate

    function automatic logic hit(input logic [31:0] addr, input logic [7:0] off);
        hit = (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
    endfunction

    // ---------------- register bus ----------------
    logic [31:0] ctrl;
    logic [NF-1:0] flags;
    logic [NE-1:0] irq_status;
    logic [NE-1:0] irq_enable;
    logic aux_en;
    logic wr_pend;
    logic [31:0] wr_addr;
    pbw_pkg::pbw_state_t state;
    logic suppress;

    wire logic take = hsel && hready && (htrans == pbw_pkg::HTRANS_NONSEQ || htrans == 2'h3);
    wire logic rd_take = take && !hwrite;
    wire logic wr_ctrl = wr_pend && hit(wr_addr, pbw_pkg::ADDR_CTRL);
    wire logic wr_clear = wr_pend && hit(wr_addr, pbw_pkg::ADDR_IRQ_CLEAR);
    wire logic wr_enable = wr_pend && hit(wr_addr, pbw_pkg::ADDR_IRQ_ENABLE);
    wire logic wr_power = wr_pend && hit(wr_addr, pbw_pkg::ADDR_POWER);
    wire logic rd_flags = rd_take && hit(haddr, pbw_pkg::ADDR_FLAGS);
    wire logic store_req = wr_power && hwdata[pbw_pkg::POWER_STORE_BIT];

    wire logic [31:0] state_word = {27'h000_0000, suppress, ~button_input_n,
        system_rail_en, digital_rail_en, (state == pbw_pkg::st_storage)};
    wire logic [31:0] rd_mux =
        hit(haddr, pbw_pkg::ADDR_CTRL) ? ctrl :
        hit(haddr, pbw_pkg::ADDR_FLAGS) ? {{(32-NF){1'b0}}, flags} :
        hit(haddr, pbw_pkg::ADDR_IRQ_STATUS) ? {{(32-NE){1'b0}}, irq_status} :
        hit(haddr, pbw_pkg::ADDR_IRQ_ENABLE) ? {{(32-NE){1'b0}}, irq_enable} :
        hit(haddr, pbw_pkg::ADDR_POWER) ? {31'h0000_0000, aux_en} :
        hit(haddr, pbw_pkg::ADDR_STATE) ? state_word : 32'h0000_0000;

    // zero wait states: read data is captured in the address phase
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= take && hwrite;
            wr_addr <= haddr;
            hrdata <= rd_take ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= pbw_pkg::CTRL_RESET;
            irq_enable <= pbw_pkg::IRQ_EN_RESET;
            aux_en <= pbw_pkg::POWER_RESET[pbw_pkg::POWER_AUX_BIT];
        end else begin
            if (wr_ctrl) begin
                ctrl <= hwdata;
            end
            if (wr_enable) begin
                irq_enable <= hwdata[NE-1:0];
            end
            if (wr_power) begin
                aux_en <= hwdata[pbw_pkg::POWER_AUX_BIT];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ---------------- timebase and button ----------------
    logic [PW-1:0] pre;
    logic tick;
    logic btn_prev;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre <= '0;
            tick <= 1'b0;
            btn_prev <= 1'b1;
        end else begin
            tick <= (pre == TICK_LAST);
            pre <= (pre == TICK_LAST) ? '0 : pre + {{(PW-1){1'b0}}, 1'b1};
            btn_prev <= button_input_n;
        end
    end

    wire logic held = ~button_input_n;
    wire logic press = btn_prev && !button_input_n;

    // ---------------- press timers ----------------
    wire logic [7:0] f_first = ctrl[pbw_pkg::CTRL_FIRST_LSB +: 8];
    wire logic [7:0] f_second = ctrl[pbw_pkg::CTRL_SECOND_LSB +: 8];
    wire logic [7:0] f_long = ctrl[pbw_pkg::CTRL_LONG_LSB +: 8];
    wire logic [3:0] f_warn = ctrl[pbw_pkg::CTRL_WARN_LSB +: 4];
    wire logic [1:0] long_press_action = ctrl[pbw_pkg::CTRL_ACTION_LSB +: 2];

    wire logic [TW-1:0] long_ticks = TW'(f_long) << pbw_pkg::LONG_SHIFT;
    wire logic [TW-1:0] warn_ticks = TW'(f_warn) << pbw_pkg::LONG_SHIFT;
    wire logic [TW-1:0] warn_point = (warn_ticks >= long_ticks) ? TW'(1) : long_ticks - warn_ticks;
    // index order: first, second, warning point, long press
    wire logic [TW-1:0] durs [4] = '{TW'(f_first), TW'(f_second), warn_point, long_ticks};
    logic [3:0] exp;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_timer
            pbw_press_timer #(.W(TW)) u_timer (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .tick(tick),
                .start(press),
                .held(held),
                .duration(durs[gi]),
                .expired(exp[gi])
            );
        end
    endgenerate

    // the second timer counts from the press too, so it only reports after the first
    logic first_seen;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            first_seen <= 1'b0;
        end else if (press || !held) begin
            first_seen <= 1'b0;
        end else if (exp[0]) begin
            first_seen <= 1'b1;
        end
    end

    wire logic report_ok = (state == pbw_pkg::st_active) && !suppress;
    wire logic ev_first = exp[0] && report_ok;
    wire logic ev_second = exp[1] && (first_seen || exp[0]) && report_ok;
    wire logic ev_warn = exp[2] && report_ok;
    wire logic long_hit = exp[3] && report_ok;
    wire logic act_pcycle = long_hit && (long_press_action == pbw_pkg::ACT_PCYCLE);
    wire logic act_store = long_hit && (long_press_action == pbw_pkg::ACT_STORAGE);
    wire logic wake_done = (state == pbw_pkg::st_wake_try) && (exp[0] || vin_valid);
    wire logic [NF-1:0] flag_set = {ev_warn, ev_second, ev_first};

    // ---------------- power state ----------------
    logic [OW-1:0] off_count;
    pbw_pkg::pbw_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            pbw_pkg::st_storage: begin
                if (press) begin
                    next_state = pbw_pkg::st_wake_try;
                end
            end
            pbw_pkg::st_wake_try: begin
                if (vin_valid) begin
                    next_state = pbw_pkg::st_active;
                end else if (exp[0]) begin
                    next_state = pbw_pkg::st_active;
                end else if (!held) begin
                    next_state = pbw_pkg::st_storage;
                end
            end
            pbw_pkg::st_active: begin
                if (act_pcycle) begin
                    next_state = pbw_pkg::st_pcycle;
                end else if (act_store || store_req) begin
                    next_state = pbw_pkg::st_storage;
                end
            end
            pbw_pkg::st_pcycle: begin
                if (off_count == OFF_LAST) begin
                    next_state = pbw_pkg::st_active;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= pbw_pkg::st_active;
            off_count <= '0;
        end else begin
            state <= next_state;
            off_count <= (state == pbw_pkg::st_pcycle) ? off_count + {{(OW-1){1'b0}}, 1'b1} : '0;
        end
    end

    // a press that completes the wake is not also reported as a short press
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            suppress <= 1'b0;
        end else if (!held) begin
            suppress <= 1'b0;
        end else if (wake_done || state == pbw_pkg::st_pcycle) begin
            suppress <= 1'b1;
        end
    end

    wire logic next_digital = (next_state != pbw_pkg::st_storage);
    wire logic next_system = (next_state == pbw_pkg::st_active);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            digital_rail_en <= 1'b1;
            system_rail_en <= 1'b1;
            aux_rail_en <= 1'b0;
        end else begin
            digital_rail_en <= next_digital;
            system_rail_en <= next_system;
            aux_rail_en <= next_system && aux_en;
        end
    end

    // ---------------- flags and interrupts ----------------
    // a flag set in the cycle of its clearing read survives the read
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~{NF{rd_flags}}) | flag_set;
        end
    end

    wire logic [NE-1:0] status_set = {wake_done, long_hit, flag_set};
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~(wr_clear ? hwdata[NE-1:0] : {NE{1'b0}})) | status_set;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // pulses fire only on a fresh flag and only while that source is unmasked
    wire logic pulse_trig = |(flag_set & ~flags & irq_enable[NF-1:0]);

    pbw_int_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .trigger(pulse_trig),
        .int_oe_n(int_oe_n)
    );

    assign int_out = 1'b0;
endmodule

// >>> verif/pbw_chk_sva.sv
// concurrent checks on the push-button wake controller ports
// assumes it is bound into pbw_top and shares its pulse length parameter
`timescale 1ns/1ps
module pbw_chk #(
    parameter int PULSE_CYCLES = 8
) (
    input wire logic sys_clk, // clock
    input wire logic rstn, // reset, active low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [31:0] hrdata, // read data
    input wire logic button_input_n, // button
    input wire logic vin_valid, // supply valid
    input wire logic int_out, // pin value
    input wire logic int_oe_n, // pin enable
    input wire logic irq, // level interrupt
    input wire logic digital_rail_en, // digital rail
    input wire logic system_rail_en, // system rail
    input wire logic aux_rail_en // aux rail
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    logic [31:0] low_cnt;
    logic from_store;
    wire rd_take = hsel && hready && htrans[1] && !hwrite;
    // from_store marks a wake attempt, so a power cycle is not taken for one
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt <= '0;
            from_store <= 1'b0;
        end else begin
            low_cnt <= int_oe_n ? 32'h0 : low_cnt + 32'h1;
            from_store <= !digital_rail_en || (from_store && !system_rail_en);
        end
    end
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or error");
    chk_pulse_len: assert property ($rose(int_oe_n) |-> low_cnt >= PULSE_CYCLES)
        else $error("interrupt pulse too short");
    chk_pin_low: assert property (!int_oe_n |-> !int_out)
        else $error("interrupt pin not driven low");
    chk_read_idle: assert property (!rd_take |=> hrdata == 32'h0)
        else $error("read data outside a read");
    chk_unmapped_read: assert property (rd_take && haddr > 32'h18 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_storage_quiet: assert property (!digital_rail_en |-> int_oe_n && !system_rail_en && !aux_rail_en)
        else $error("activity while in storage");
    chk_press_wakes: assert property (!digital_rail_en && $fell(button_input_n) |-> ##[1:3] digital_rail_en)
        else $error("press did not enable digital rail");
    chk_pcycle_off: assert property ($fell(system_rail_en) && digital_rail_en |-> !system_rail_en [*8])
        else $error("power cycle off time too short");
    chk_vin_wake: assert property (from_store && digital_rail_en && vin_valid |-> ##[1:3] system_rail_en)
        else $error("valid supply did not end wake");
endmodule

bind pbw_top pbw_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .button_input_n(button_input_n), .vin_valid(vin_valid),
    .int_out(int_out), .int_oe_n(int_oe_n), .irq(irq), .digital_rail_en(digital_rail_en),
    .system_rail_en(system_rail_en), .aux_rail_en(aux_rail_en)
);

// >>> verif/pbw_host_model.sv
// host side of the interrupt pin: pull-up, pulse counter and width meter
// assumes the pin is open drain and nothing else pulls it
`timescale 1ns/1ps
module pbw_host_model (
    input wire logic sys_clk, // clock
    input wire logic int_out, // value driven onto the pin
    input wire logic int_oe_n, // low while the device drives
    output logic int_pin, // resolved pin level
    output logic [31:0] n_pulse, // pulses seen
    output logic [31:0] last_w // low cycles of the last pulse
);
    logic [31:0] w;
    // released pin floats up through the external pull-up
    assign int_pin = int_oe_n ? 1'b1 : int_out;
    initial begin
        n_pulse = 32'h0;
        last_w = 32'h0;
        w = 32'h0;
    end
    // a pulse is counted when it ends, so readers wait past its length
    always @(posedge sys_clk) begin
        if (int_pin === 1'b0) begin
            w <= w + 32'h1;
        end else begin
            if (w != 32'h0) begin
                n_pulse <= n_pulse + 32'h1;
                last_w <= w;
            end
            w <= 32'h0;
        end
    end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the push-button wake controller
// assumes shortened tick, pulse and power-cycle counts and one bus master
`timescale 1ns/1ps
module testbench;
    localparam int TK = 4;
    localparam int PC = 8;
    localparam int CO = 10;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic btn_n = 1'b1;
    logic vin = 1'b0;
    wire logic hreadyout, hresp, int_out, int_oe_n, irq, dig, sys, aux, int_pin;
    wire logic [31:0] hrdata, n_pulse, last_w;
    logic [31:0] rd;
    logic [31:0] p0;
    int n_fail = 0;
    int num_checks = 0;
    int f;
    int cnt;
    pbw_top #(.TICK_CYCLES(TK), .PULSE_CYCLES(PC), .CYCLE_OFF_CYCLES(CO)) u_dut (
        .sys_clk(sys_clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .button_input_n(btn_n),
        .vin_valid(vin), .int_out(int_out), .int_oe_n(int_oe_n), .irq(irq),
        .digital_rail_en(dig), .system_rail_en(sys), .aux_rail_en(aux)
    );
    pbw_host_model u_host (
        .sys_clk(sys_clk), .int_out(int_out), .int_oe_n(int_oe_n), .int_pin(int_pin),
        .n_pulse(n_pulse), .last_w(last_w)
    );
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= pbw_pkg::HTRANS_NONSEQ;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic rdr(input logic [7:0] a);
        ahb(1'b0, a, 32'h0);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t level %b expected %b", $time, got, exp);
        end
    endtask
    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask
    function automatic logic [31:0] ctrl_word(input int fd, sd, ld, wn, act);
        return {2'b00, act[1:0], wn[3:0], ld[7:0], sd[7:0], fd[7:0]};
    endfunction
    function automatic logic [31:0] exp_pulses(input logic [2:0] en, input logic [2:0] fresh);
        return $countones(en & fresh);
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hE14717E9));
        f = 4 + $urandom % 4;
        hold(2);
        rstn <= 1'b1;
        hold(1);
        rdr(pbw_pkg::ADDR_CTRL);
        chk_reg(rd, pbw_pkg::CTRL_RESET);
        rdr(pbw_pkg::ADDR_IRQ_ENABLE);
        chk_reg(rd, {27'h0, pbw_pkg::IRQ_EN_RESET});
        rdr(pbw_pkg::ADDR_STATE);
        chk_reg(rd, 32'h6);
        ahb(1'b1, 8'h1C, 32'hFFFFFFFF);
        rdr(8'h1C);
        chk_reg(rd, 32'h0);
        end_test("reset");
        ahb(1'b1, pbw_pkg::ADDR_CTRL, ctrl_word(f, f + 3, 2, 1, 2));
        rdr(pbw_pkg::ADDR_CTRL);
        chk_reg(rd, ctrl_word(f, f + 3, 2, 1, 2));
        p0 = n_pulse;
        btn_n <= 1'b0;
        hold(200);
        chk_reg(last_w, PC);
        btn_n <= 1'b1;
        hold(20);
        chk_reg(n_pulse - p0, exp_pulses(3'h7, 3'h7));
        chk_bit(irq, 1'b1);
        p0 = n_pulse;
        btn_n <= 1'b0;
        hold(200);
        btn_n <= 1'b1;
        hold(20);
        chk_reg(n_pulse - p0, 32'h0);
        rdr(pbw_pkg::ADDR_FLAGS);
        chk_reg(rd, 32'h7);
        rdr(pbw_pkg::ADDR_FLAGS);
        chk_reg(rd, 32'h0);
        ahb(1'b1, pbw_pkg::ADDR_IRQ_CLEAR, 32'h1F);
        hold(2);
        chk_bit(irq, 1'b0);
        end_test("presses");
        ahb(1'b1, pbw_pkg::ADDR_IRQ_ENABLE, 32'h0);
        p0 = n_pulse;
        btn_n <= 1'b0;
        hold(100);
        chk_bit(irq, 1'b0);
        ahb(1'b1, pbw_pkg::ADDR_IRQ_ENABLE, 32'h7);
        hold(100);
        btn_n <= 1'b1;
        hold(20);
        chk_reg(n_pulse - p0, exp_pulses(3'h0, 3'h7));
        rdr(pbw_pkg::ADDR_FLAGS);
        chk_reg(rd, 32'h7);
        ahb(1'b1, pbw_pkg::ADDR_IRQ_CLEAR, 32'h1F);
        end_test("mask");
        // rewrite mid-press: the running timer must keep the old duration
        btn_n <= 1'b0;
        hold(2);
        ahb(1'b1, pbw_pkg::ADDR_CTRL, ctrl_word(64, 80, 2, 1, 2));
        hold(f * TK);
        rdr(pbw_pkg::ADDR_FLAGS);
        chk_reg(rd & 32'h1, 32'h1);
        btn_n <= 1'b1;
        hold(20);
        btn_n <= 1'b0;
        hold(f * TK + 8);
        rdr(pbw_pkg::ADDR_FLAGS);
        chk_reg(rd, 32'h0);
        btn_n <= 1'b1;
        hold(20);
        ahb(1'b1, pbw_pkg::ADDR_CTRL, ctrl_word(f, f + 3, 2, 1, 0));
        end_test("retime");
        btn_n <= 1'b0;
        for (cnt = 0; cnt < 400 && sys !== 1'b0; cnt++) @(posedge sys_clk);
        chk_bit(dig, 1'b1);
        cnt = 0;
        while (sys !== 1'b1 && cnt < 100) begin
            @(posedge sys_clk);
            cnt++;
        end
        chk_reg(cnt, CO);
        btn_n <= 1'b1;
        hold(20);
        rdr(pbw_pkg::ADDR_FLAGS);
        chk_reg(rd, 32'h7);
        end_test("power cycle");
        ahb(1'b1, pbw_pkg::ADDR_POWER, 32'h3);
        hold(3);
        chk_bit(dig, 1'b0);
        btn_n <= 1'b0;
        hold(3);
        chk_bit(dig, 1'b1);
        btn_n <= 1'b1;
        hold(6);
        chk_bit(dig, 1'b0);
        chk_bit(sys, 1'b0);
        p0 = n_pulse;
        btn_n <= 1'b0;
        hold(f * TK + 8);
        chk_bit(sys, 1'b1);
        chk_bit(aux, 1'b1);
        hold(200);
        chk_bit(sys, 1'b1);
        btn_n <= 1'b1;
        hold(20);
        chk_reg(n_pulse - p0, 32'h0);
        rdr(pbw_pkg::ADDR_IRQ_STATUS);
        chk_reg(rd & 32'h10, 32'h10);
        btn_n <= 1'b0;
        hold(f * TK + 8);
        btn_n <= 1'b1;
        hold(20);
        rdr(pbw_pkg::ADDR_FLAGS);
        chk_reg(rd & 32'h1, 32'h1);
        ahb(1'b1, pbw_pkg::ADDR_POWER, 32'h3);
        hold(3);
        btn_n <= 1'b0;
        hold(2);
        vin <= 1'b1;
        hold(4);
        chk_bit(sys, 1'b1);
        btn_n <= 1'b1;
        vin <= 1'b0;
        hold(10);
        ahb(1'b1, pbw_pkg::ADDR_CTRL, ctrl_word(f, f + 3, 2, 1, 1));
        btn_n <= 1'b0;
        hold(200);
        chk_bit(dig, 1'b0);
        btn_n <= 1'b1;
        hold(10);
        end_test("storage");
        give_verdict();
    end
endmodule
